// File: radio_cfg.svh
// constants for the radio host pin block
`ifndef RADIO_CFG_SVH
`define RADIO_CFG_SVH
// ****************************************
// timing
// ****************************************
`define RADIO_CLK_HZ 100000000
`define RADIO_BAUD 115200
`define RADIO_BIT_CYCLES ((`RADIO_CLK_HZ + `RADIO_BAUD / 2) / `RADIO_BAUD)
`define RADIO_ACK_WAIT_US 20
`define RADIO_ACK_WAIT_CYCLES (`RADIO_ACK_WAIT_US * (`RADIO_CLK_HZ / 1000000))
`define RADIO_PB_GAP_MS 500
`define RADIO_PB_GAP_CYCLES (`RADIO_PB_GAP_MS * (`RADIO_CLK_HZ / 1000))
`define RADIO_FLASH_MS 1000
`define RADIO_FLASH_CYCLES (`RADIO_FLASH_MS * (`RADIO_CLK_HZ / 1000))
// ****************************************
// register offsets (byte addresses)
// ****************************************
`define RADIO_REG_CTRL 8'h00
`define RADIO_REG_FMASK 8'h04
`define RADIO_REG_STATUS 8'h08
`define RADIO_REG_IMASK 8'h0c
`define RADIO_REG_CMD 8'h10
`define RADIO_REG_REPLY 8'h14
`define RADIO_REG_LINES 8'h18
// ****************************************
// fields and reset values
// ****************************************
`define RADIO_CTRL_ACKEN 0
`define RADIO_CTRL_RETRY_LSB 8
`define RADIO_CMD_VALID 8
`define RADIO_EV_W 7
`define RADIO_EV_CMD 0
`define RADIO_EV_TXDONE 1
`define RADIO_EV_RETRY 2
`define RADIO_EV_FRAME 3
`define RADIO_EV_OVR 4
`define RADIO_EV_JOIN 5
`define RADIO_EV_DEFAULT 6
`define RADIO_ACKEN_RST 1'h0
`define RADIO_RETRY_RST 4'h3
`define RADIO_FMASK_RST 7'h1c
`define RADIO_PB_JOIN_PRESSES 3'h2
`define RADIO_PB_DEFAULT_PRESSES 3'h4
// pin vector order: serial, select, sleep_n, button
`define RADIO_PIN_SER 3
`define RADIO_PIN_CMD 2
`define RADIO_PIN_SLP 1
`define RADIO_PIN_BTN 0
`define RADIO_PIN_RST 4'ha
`endif

// File: radio_pkg.sv
// types shared by the radio host pin block
package radio_pkg;
   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_SEND = 2'b01,
      TX_WAIT = 2'b10
   } txfsm_type;
endpackage

// File: byte_if.sv
// byte stream carrier between the serial engines and the core
`timescale 1ns/1ps
interface byte_if;
   logic valid;
   logic ready;
   logic [7:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// File: uart_rx.sv
// serial byte receiver, 8n1, on an already synchronised line
`timescale 1ns/1ps
`include "radio_cfg.svh"
module uart_rx (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic serialLevel,
   byte_if.src rxOut,
   output logic frameError
);
   logic busy;
   logic [3:0] bitIdx;
   logic [9:0] cnt;
   logic [7:0] shift;
   logic valid;
   wire tick = busy && (cnt == 10'h000);
   assign rxOut.valid = valid;
   assign rxOut.data = shift;
   // ****************************************
   // sampling at bit centres
   // ****************************************
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         busy <= 1'b0;
         bitIdx <= 4'h0;
         cnt <= 10'h000;
         shift <= 8'h00;
         valid <= 1'b0;
         frameError <= 1'b0;
      end else begin
         valid <= 1'b0;
         frameError <= 1'b0;
         if (!busy) begin
            if (!serialLevel) begin
               busy <= 1'b1;
               bitIdx <= 4'h0;
               cnt <= 10'(`RADIO_BIT_CYCLES / 2);
            end
         end else if (!tick) begin
            cnt <= cnt - 10'h001;
         end else begin
            cnt <= 10'(`RADIO_BIT_CYCLES - 1);
            bitIdx <= bitIdx + 4'h1;
            // glitch on start bit is dropped silently
            if (bitIdx == 4'h0 && serialLevel) begin
               busy <= 1'b0;
            end else if (bitIdx >= 4'h1 && bitIdx <= 4'h8) begin
               shift <= {serialLevel, shift[7:1]};
            end else if (bitIdx == 4'h9) begin
               busy <= 1'b0;
               valid <= serialLevel && rxOut.ready;
               frameError <= !serialLevel;
            end
         end
      end
   end
endmodule

// File: uart_tx.sv
// serial byte transmitter, 8n1
`timescale 1ns/1ps
`include "radio_cfg.svh"
module uart_tx (
   input wire logic clk_sys,
   input wire logic resetn,
   byte_if.snk txIn,
   output logic serialLine
);
   logic busy;
   logic [3:0] bitIdx;
   logic [9:0] cnt;
   logic [9:0] shift;
   assign txIn.ready = !busy;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         busy <= 1'b0;
         bitIdx <= 4'h0;
         cnt <= 10'h000;
         shift <= 10'h3ff;
         serialLine <= 1'b1;
      end else if (!busy) begin
         serialLine <= 1'b1;
         if (txIn.valid) begin
            busy <= 1'b1;
            bitIdx <= 4'h0;
            cnt <= 10'(`RADIO_BIT_CYCLES - 1);
            shift <= {1'b1, txIn.data, 1'b0};
            serialLine <= 1'b0;
         end
      end else if (cnt != 10'h000) begin
         cnt <= cnt - 10'h001;
      end else begin
         cnt <= 10'(`RADIO_BIT_CYCLES - 1);
         bitIdx <= bitIdx + 4'h1;
         shift <= {1'b1, shift[9:1]};
         serialLine <= shift[1];
         if (bitIdx == 4'h9) begin
            busy <= 1'b0;
            serialLine <= 1'b1;
         end
      end
   end
endmodule

// File: radio_host_pins.sv
// host pin block of the packet radio: serial lines, status lines, registers
//
// Design decisions made here: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`include "radio_cfg.svh"
module radio_host_pins #(
   parameter int unsigned PB_GAP_CYCLES = `RADIO_PB_GAP_CYCLES,
   parameter int unsigned FLASH_CYCLES = `RADIO_FLASH_CYCLES
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic irq,
   input wire logic serialIn,
   input wire logic cmdSelect,
   input wire logic sleepReq_n,
   input wire logic button_input,
   output logic serialOut,
   output logic reply_flag_n,
   output logic fault_line,
   output logic clearToSend_n,
   output logic tx_buffer_empty,
   output logic activity_indicator,
   output logic rx_amp_enable,
   output logic tx_amp_enable,
   output logic [7:0] airTxData,
   output logic airTxValid,
   input wire logic airTxReady,
   input wire logic airAckSeen,
   input wire logic airReceiving,
   input wire logic [7:0] airRxData,
   input wire logic airRxValid,
   output logic airRxReady
);
   // ****************************************
   // pin synchronisers and serial engines
   // ****************************************
   logic [3:0] pinS1, pinS2, pinS3, pinState;
   wire [3:0] pinRaw = {serialIn, cmdSelect, sleepReq_n, button_input};
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         {pinS1, pinS2, pinS3, pinState} <= {4{`RADIO_PIN_RST}};
      end else begin
         {pinS3, pinS2, pinS1} <= {pinS2, pinS1, pinRaw};
         // a bit moves only once two stages agree
         pinState <= (pinS2 & pinS3) | (pinState & (pinS2 ^ pinS3));
      end
   end
   wire awake = pinState[`RADIO_PIN_SLP];
   wire selData = pinState[`RADIO_PIN_CMD];
   wire btn = pinState[`RADIO_PIN_BTN];
   byte_if rxBus ();
   byte_if txBus ();
   logic frameErr;
   uart_rx rxEngine (.clk_sys(clk_sys), .resetn(resetn),
      .serialLevel(pinState[`RADIO_PIN_SER]), .rxOut(rxBus), .frameError(frameErr));
   uart_tx txEngine (.clk_sys(clk_sys), .resetn(resetn), .txIn(txBus),
      .serialLine(serialOut));
   assign rxBus.ready = awake;
   // ****************************************
   // bus decode and byte routing
   // ****************************************
   wire wbHit = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire wrLo = wbHit && wb_we_i && wb_sel_i[0];
   wire wrHi = wbHit && wb_we_i && wb_sel_i[1];
   wire rdHit = wbHit && !wb_we_i;
   wire selCtrl = wb_adr_i == `RADIO_REG_CTRL;
   wire selFmask = wb_adr_i == `RADIO_REG_FMASK;
   wire selStatus = wb_adr_i == `RADIO_REG_STATUS;
   wire selImask = wb_adr_i == `RADIO_REG_IMASK;
   wire selCmd = wb_adr_i == `RADIO_REG_CMD;
   wire selReply = wb_adr_i == `RADIO_REG_REPLY;
   wire selLines = wb_adr_i == `RADIO_REG_LINES;
   logic ackEnable;
   logic [3:0] retryLimit;
   logic [6:0] faultMask, irqMask, status;
   logic [7:0] cmdByte, payByte, replyByte, airHold;
   logic cmdValid, payValid, replyValid, airHoldValid;
   logic [2:0] pressCount;
   radio_pkg::txfsm_type txState;
   wire statusClr = rdHit && selStatus;
   wire cmdPop = rdHit && selCmd;
   wire toCmd = rxBus.valid && !selData;
   wire toPay = rxBus.valid && selData;
   wire cmdOvr = toCmd && cmdValid && !cmdPop;
   wire payOvr = toPay && payValid;
   wire replyOvr = wrLo && selReply && replyValid;
   logic txDone, retryFail, joinEv, defaultEv;
   wire [6:0] events = {defaultEv, joinEv, cmdOvr || payOvr || replyOvr,
      frameErr && awake, retryFail, txDone, toCmd && !cmdOvr};
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cmdValid <= 1'b0;
         cmdByte <= 8'h00;
      end else if (toCmd && !cmdOvr) begin
         cmdValid <= 1'b1;
         cmdByte <= rxBus.data;
      end else if (cmdPop) begin
         cmdValid <= 1'b0;
      end
   end
   // ****************************************
   // over-air send with retries, serial output sharing
   // ****************************************
   logic [10:0] waitCnt;
   logic [3:0] retries;
   wire waitDone = waitCnt == 11'(`RADIO_ACK_WAIT_CYCLES - 1);
   assign airTxData = payByte;
   assign airTxValid = txState == radio_pkg::TX_SEND;
   assign txDone = awake && ((airTxValid && airTxReady && !ackEnable) ||
      (txState == radio_pkg::TX_WAIT && airAckSeen));
   assign retryFail = awake && txState == radio_pkg::TX_WAIT && !airAckSeen &&
      waitDone && retries == retryLimit;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         txState <= radio_pkg::TX_IDLE;
         {payValid, payByte} <= 9'h000;
         {waitCnt, retries} <= 15'h0000;
      end else begin
         if (toPay && !payValid) begin
            payValid <= 1'b1;
            payByte <= rxBus.data;
         end
         if (!awake) begin
            txState <= radio_pkg::TX_IDLE;
         end else begin
            unique case (txState)
               radio_pkg::TX_IDLE: begin
                  retries <= 4'h0;
                  if (payValid) begin
                     txState <= radio_pkg::TX_SEND;
                  end
               end
               radio_pkg::TX_SEND: begin
                  waitCnt <= 11'h000;
                  if (airTxReady) begin
                     txState <= ackEnable ? radio_pkg::TX_WAIT : radio_pkg::TX_IDLE;
                     payValid <= ackEnable;
                  end
               end
               radio_pkg::TX_WAIT: begin
                  waitCnt <= waitCnt + 11'h001;
                  if (airAckSeen || retryFail) begin
                     txState <= radio_pkg::TX_IDLE;
                     payValid <= 1'b0;
                  end else if (waitDone) begin
                     retries <= retries + 4'h1;
                     txState <= radio_pkg::TX_SEND;
                  end
               end
               default: begin
                  txState <= radio_pkg::TX_IDLE;
               end
            endcase
         end
      end
   end
   assign txBus.valid = replyValid || airHoldValid;
   assign txBus.data = replyValid ? replyByte : airHold;
   assign airRxReady = awake && !airHoldValid;
   wire txHs = txBus.valid && txBus.ready;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         {replyValid, replyByte, airHoldValid, airHold} <= 18'h00000;
         reply_flag_n <= 1'b1;
      end else begin
         if (wrLo && selReply && !replyValid) begin
            replyValid <= 1'b1;
            replyByte <= wb_dat_i[7:0];
         end else if (txHs && replyValid) begin
            replyValid <= 1'b0;
         end
         if (airRxValid && airRxReady) begin
            airHoldValid <= 1'b1;
            airHold <= airRxData;
         end else if (txHs && !replyValid) begin
            airHoldValid <= 1'b0;
         end
         if (txHs) begin
            reply_flag_n <= !replyValid;
         end else if (txBus.ready) begin
            reply_flag_n <= 1'b1;
         end
      end
   end
   // ****************************************
   // button sequences and activity flash
   // ****************************************
   logic btnPrev;
   logic [26:0] gapCnt;
   wire gapEnd = !btn && pressCount != 3'h0 && gapCnt == 27'(PB_GAP_CYCLES - 1);
   assign joinEv = gapEnd && pressCount == `RADIO_PB_JOIN_PRESSES;
   assign defaultEv = gapEnd && pressCount == `RADIO_PB_DEFAULT_PRESSES;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         {btnPrev, pressCount, gapCnt} <= 31'h00000000;
      end else begin
         btnPrev <= btn;
         if (btn || gapEnd) begin
            gapCnt <= 27'h0000000;
         end else if (pressCount != 3'h0) begin
            gapCnt <= gapCnt + 27'h0000001;
         end
         if (gapEnd || !awake) begin
            pressCount <= 3'h0;
         end else if (btn && !btnPrev && pressCount != 3'h7) begin
            pressCount <= pressCount + 3'h1;
         end
      end
   end
   logic [26:0] flashCnt;
   wire busy = txState != radio_pkg::TX_IDLE || payValid;
   wire [26:0] onLimit = busy ? 27'(FLASH_CYCLES / 2) : 27'(FLASH_CYCLES / 16);
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         {flashCnt, activity_indicator} <= 28'h0000000;
      end else begin
         flashCnt <= (flashCnt == 27'(FLASH_CYCLES - 1)) ? 27'h0000000 :
            flashCnt + 27'h0000001;
         activity_indicator <= awake && flashCnt < onLimit;
      end
   end
   // ****************************************
   // status lines and registers
   // ****************************************
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         {clearToSend_n, tx_buffer_empty} <= 2'h3;
         {rx_amp_enable, tx_amp_enable, fault_line, irq} <= 4'h0;
      end else begin
         clearToSend_n <= !(awake && !payValid && !cmdValid);
         tx_buffer_empty <= !payValid && txState == radio_pkg::TX_IDLE;
         rx_amp_enable <= awake && airReceiving && txState != radio_pkg::TX_SEND;
         tx_amp_enable <= awake && txState == radio_pkg::TX_SEND;
         fault_line <= |(status & faultMask);
         irq <= |(status & irqMask);
      end
   end
   wire [31:0] lineWord = {22'h000000, pressCount, txState, !awake, selData,
      clearToSend_n, tx_buffer_empty, reply_flag_n};
   wire [31:0] readWord =
      selCtrl ? {20'h00000, retryLimit, 7'h00, ackEnable} :
      selFmask ? {25'h0000000, faultMask} :
      selStatus ? {25'h0000000, status} :
      selImask ? {25'h0000000, irqMask} :
      selCmd ? {23'h000000, cmdValid, cmdByte} :
      selReply ? {31'h00000000, replyValid} :
      selLines ? lineWord : 32'h00000000;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ackEnable <= `RADIO_ACKEN_RST;
         retryLimit <= `RADIO_RETRY_RST;
         faultMask <= `RADIO_FMASK_RST;
         {irqMask, status} <= 14'h0000;
         {wb_ack_o, wb_dat_o} <= 33'h000000000;
      end else begin
         wb_ack_o <= wbHit;
         wb_dat_o <= rdHit ? readWord : 32'h00000000;
         if (wrLo && selCtrl) ackEnable <= wb_dat_i[`RADIO_CTRL_ACKEN];
         if (wrHi && selCtrl) retryLimit <= wb_dat_i[`RADIO_CTRL_RETRY_LSB +: 4];
         if (wrLo && selFmask) faultMask <= wb_dat_i[6:0];
         if (wrLo && selImask) irqMask <= wb_dat_i[6:0];
         // new events win over the read clear
         status <= (status & {7{!statusClr}}) | events;
      end
   end
   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   sequence replyStart;
      txHs && replyValid;
   endsequence
   sequence lastTimeout;
      retryFail ##1 1'b1;
   endsequence
   AST_REPLY_FLAG: assert property (replyStart |=> (!reply_flag_n)[*8])
      else $error("reply flag not low during reply");
   AST_FAULT: assert property ((status & faultMask) != 7'h00 |=> fault_line)
      else $error("fault line missing");
   AST_SLEEP: assert property (!awake |=> clearToSend_n && !tx_amp_enable)
      else $error("active while asleep");
   AST_CMD_ROUTE: assert property (toCmd && !cmdValid |=> cmdValid &&
      payByte == $past(payByte)) else $error("command byte misrouted");
   AST_TX_AMP: assert property ($rose(tx_amp_enable) |->
      $past(txState) == radio_pkg::TX_SEND) else $error("amp without send");
   AST_CTS: assert property (payValid |=> clearToSend_n)
      else $error("clear to send while holding");
   AST_BE: assert property (payValid |=> !tx_buffer_empty)
      else $error("empty while holding");
   AST_ACK_WAIT: assert property (txState == radio_pkg::TX_WAIT |=>
      !tx_buffer_empty) else $error("empty before ack");
   AST_RETRY: assert property (lastTimeout |-> status[`RADIO_EV_RETRY] &&
      txState == radio_pkg::TX_IDLE) else $error("retry exception missing");
   AST_WB_ACK: assert property (wbHit |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus ack not one cycle");
endmodule

// File: host_model.sv
// host side serial sender for the radio pin block
`timescale 1ns/1ps
`include "radio_cfg.svh"
module host_model (
   input wire logic clk_sys,
   input wire logic clearToSend_n,
   output logic serialIn,
   output logic cmdSelect
);
   // idle line high, as a host uart leaves it
   initial begin
      serialIn = 1'h1;
      cmdSelect = 1'h0;
   end
   task automatic send(input logic [7:0] b, input logic sel);
      logic [9:0] frame;
      frame = {1'h1, b, 1'h0};
      while (clearToSend_n !== 1'h0) @(posedge clk_sys);
      cmdSelect <= sel;
      for (int i = 0; i < 10; i++) begin
         serialIn <= frame[i];
         repeat (`RADIO_BIT_CYCLES) @(posedge clk_sys);
      end
   endtask
endmodule

// File: test_radio_host_pins.sv
// self-checking bench for the radio host pin block
`timescale 1ns/1ps
`include "radio_cfg.svh"
module test_radio_host_pins;
   logic clk_sys, resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq, serialIn, cmdSelect;
   logic sleepReq_n, serialOut, reply_flag_n, fault_line, clearToSend_n, tx_buffer_empty;
   logic activity_indicator, rx_amp_enable, tx_amp_enable, airTxValid, airTxReady, airRxReady;
   logic airReceiving;
   logic [7:0] wb_adr_i, airTxData, b, airRxData;
   logic [3:0] wb_sel_i, selBits;
   logic button_input, airAckSeen, airRxValid;
   int onCnt;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic [63:0] notes[$];
   logic [63:0] n;
   int fails = 0;
   int cmpCount = 0;
   int ticks = 0;
   radio_host_pins #(.PB_GAP_CYCLES(200), .FLASH_CYCLES(64)) uut (
      .clk_sys, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq, .serialIn, .cmdSelect, .sleepReq_n,
      .button_input, .serialOut, .reply_flag_n, .fault_line, .clearToSend_n,
      .tx_buffer_empty, .activity_indicator, .rx_amp_enable, .tx_amp_enable, .airTxData,
      .airTxValid, .airTxReady, .airAckSeen, .airReceiving, .airRxData,
      .airRxValid, .airRxReady);
   host_model host (.clk_sys, .clearToSend_n, .serialIn, .cmdSelect);
   initial begin
      clk_sys = 1'h0;
      forever #5 clk_sys = ~clk_sys;
   end
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmpCount, fails);
      if (fails == 0 && cmpCount > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmpCount++;
      if (got !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one classic cycle; a read leaves its masked expectation in the queue
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [63:0] e);
      if (!w) notes.push_back(e);
      @(posedge clk_sys);
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i <= w;
      wb_sel_i <= selBits;
      wb_adr_i <= a;
      wb_dat_i <= d;
      @(posedge clk_sys);
      while (wb_ack_o !== 1'h1) @(posedge clk_sys);
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
   endtask
   task automatic waitv(ref logic s, input logic v, input int lim);
      while (s !== v && lim > 0) begin
         lim--;
         @(posedge clk_sys);
      end
   endtask
   // presses long enough to pass the pin synchroniser
   task automatic press(input int k);
      repeat (k) begin
         button_input <= 1'h1;
         repeat (8) @(posedge clk_sys);
         button_input <= 1'h0;
         repeat (8) @(posedge clk_sys);
      end
   endtask
   // on-cycles over one full flash period of 64
   task automatic flashOn(output int c);
      c = 0;
      repeat (64) begin
         @(posedge clk_sys);
         c += int'(activity_indicator);
      end
   endtask
   // read data is judged at the ack edge, against the oldest note
   always @(posedge clk_sys) begin
      if (wb_ack_o === 1'h1 && wb_we_i === 1'h0) begin
         n = notes.pop_front();
         chk("read data", n[31:0], wb_dat_o & n[63:32]);
      end
   end
   // hang guard, well above the expected run length
   always @(posedge clk_sys) begin
      ticks++;
      if (ticks == 80000) begin
         fails++;
         give_verdict();
      end
   end
   initial begin
      resetn = 1'h0;
      {wb_cyc_i, wb_stb_i, wb_we_i, airTxReady, airReceiving} = 5'h0;
      {wb_sel_i, selBits} = 8'h03;
      {button_input, airAckSeen, airRxValid} = 3'h0;
      airRxData = 8'h00;
      wb_adr_i = 8'h0;
      wb_dat_i = 32'h0;
      sleepReq_n = 1'h1;
      b = 8'($urandom(32'h14ae));
      repeat (4) @(posedge clk_sys);
      chk("reset pins", 32'hf, 32'({serialOut, reply_flag_n, clearToSend_n, tx_buffer_empty}));
      resetn <= 1'h1;
      repeat (4) @(posedge clk_sys);
      chk("cts after reset", 32'h0, 32'(clearToSend_n));
      wb(0, `RADIO_REG_CTRL, 0, {32'hf01, 32'h300});
      wb(0, `RADIO_REG_FMASK, 0, {32'h7f, 32'h1c});
      wb(1, 8'h40, 32'h5a, 0);
      wb(0, 8'h40, 0, {32'hffffffff, 32'h0});
      flashOn(onCnt);
      chk("flash idle", 32'h4, 32'(onCnt));
      $display("done registers");
      sleepReq_n <= 1'h0;
      repeat (8) @(posedge clk_sys);
      chk("asleep", 32'h4, 32'({clearToSend_n, activity_indicator, airRxReady}));
      sleepReq_n <= 1'h1;
      airReceiving <= 1'h1;
      repeat (8) @(posedge clk_sys);
      chk("rx amp", 32'h1, 32'(rx_amp_enable));
      airReceiving <= 1'h0;
      $display("done sleep and amp");
      wb(1, `RADIO_REG_IMASK, 32'h1, 0);
      selBits = 4'h2;
      wb(1, `RADIO_REG_IMASK, 32'h7f, 0);
      selBits = 4'h3;
      wb(0, `RADIO_REG_IMASK, 0, {32'h7f, 32'h1});
      host.send(b, 1'h0);
      waitv(irq, 1'h1, 2000);
      chk("irq on command", 32'h1, 32'(irq));
      wb(0, `RADIO_REG_CMD, 0, {32'h1ff, 24'h1, b});
      wb(0, `RADIO_REG_STATUS, 0, {32'h1, 32'h1});
      repeat (3) @(posedge clk_sys);
      chk("irq cleared", 32'h0, 32'(irq));
      $display("done command byte");
      b = 8'($urandom());
      host.send(b, 1'h1);
      waitv(airTxValid, 1'h1, 2000);
      repeat (3) @(posedge clk_sys);
      chk("air byte", {24'h0, b}, {24'h0, airTxData});
      chk("sending", 32'h1, 32'({tx_buffer_empty, tx_amp_enable}));
      airTxReady <= 1'h1;
      waitv(tx_buffer_empty, 1'h1, 20);
      chk("empty, irq masked", 32'h2, 32'({tx_buffer_empty, irq}));
      wb(0, `RADIO_REG_STATUS, 0, {32'h2, 32'h2});
      $display("done payload");
      wb(1, `RADIO_REG_CTRL, 32'h101, 0);
      host.send(b ^ 8'hff, 1'h1);
      repeat (1500) @(posedge clk_sys);
      chk("empty waits ack", 32'h0, 32'(tx_buffer_empty));
      flashOn(onCnt);
      chk("flash busy", 32'h20, 32'(onCnt));
      waitv(tx_buffer_empty, 1'h1, 8000);
      chk("retry fault", 32'h3, 32'({tx_buffer_empty, fault_line}));
      wb(0, `RADIO_REG_STATUS, 0, {32'h4, 32'h4});
      repeat (3) @(posedge clk_sys);
      chk("fault cleared", 32'h0, 32'(fault_line));
      $display("done retry");
      host.send(b, 1'h1);
      airAckSeen <= 1'h1;
      @(posedge clk_sys);
      airAckSeen <= 1'h0;
      waitv(tx_buffer_empty, 1'h1, 10);
      chk("empty after ack", 32'h1, 32'(tx_buffer_empty));
      wb(0, `RADIO_REG_STATUS, 0, {32'h6, 32'h2});
      $display("done ack");
      press(2);
      repeat (300) @(posedge clk_sys);
      wb(0, `RADIO_REG_STATUS, 0, {32'h60, 32'h20});
      press(4);
      repeat (300) @(posedge clk_sys);
      wb(0, `RADIO_REG_STATUS, 0, {32'h60, 32'h40});
      $display("done button");
      b = 8'($urandom());
      wb(1, `RADIO_REG_REPLY, {24'h0, b}, 0);
      waitv(reply_flag_n, 1'h0, 50);
      chk("reply start", 32'h0, 32'({reply_flag_n, serialOut}));
      repeat (`RADIO_BIT_CYCLES * 3 / 2) @(posedge clk_sys);
      chk("reply bit0", 32'(b[0]), 32'(serialOut));
      waitv(reply_flag_n, 1'h1, 12000);
      chk("reply end", 32'h3, 32'({reply_flag_n, serialOut}));
      $display("done reply");
      b = 8'($urandom());
      airRxData <= b;
      airRxValid <= 1'h1;
      @(posedge clk_sys);
      airRxValid <= 1'h0;
      waitv(serialOut, 1'h0, 20);
      chk("air out start", 32'h2, 32'({reply_flag_n, serialOut}));
      repeat (`RADIO_BIT_CYCLES * 3 / 2) @(posedge clk_sys);
      chk("air out bit0", 32'(b[0]), 32'(serialOut));
      $display("done air receive");
      give_verdict();
   end
endmodule
